// >>> design/ppcc_pkg.sv
// package: constants and carriers for the pipe channel control block
package ppcc_pkg;

	// apb register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] STAT_OFS    = 8'h04;
	localparam logic [7:0] CFG_OFS     = 8'h08;

	// ctrl field positions
	localparam int CTRL_EI_INF_BIT  = 0;
	localparam int CTRL_DEEMPH_BIT  = 1;
	localparam int CTRL_COMPL_BIT   = 2;

	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// power state encodings
	localparam logic [1:0] PWR_P0  = 2'h0;
	localparam logic [1:0] PWR_P0S = 2'h1;
	localparam logic [1:0] PWR_P1  = 2'h2;
	localparam logic [1:0] PWR_P2  = 2'h3;

	// receive status encodings
	localparam logic [2:0] RXST_OK       = 3'h0;
	localparam logic [2:0] RXST_SKP_ADD  = 3'h1;
	localparam logic [2:0] RXST_SKP_DEL  = 3'h2;
	localparam logic [2:0] RXST_DETECTED = 3'h3;
	localparam logic [2:0] RXST_DEC_ERR  = 3'h4;
	localparam logic [2:0] RXST_OVF      = 3'h5;
	localparam logic [2:0] RXST_UNF      = 3'h6;
	localparam logic [2:0] RXST_DISP_ERR = 3'h7;

	// timing
	localparam int CLK_PERIOD_PS    = 4000;
	localparam int RATE_SW_NS       = 64;
	localparam int RATE_SW_CYC      = (RATE_SW_NS * 1000) / CLK_PERIOD_PS;
	localparam int PWR_SW_NS        = 16;
	localparam int PWR_SW_CYC       = (PWR_SW_NS * 1000) / CLK_PERIOD_PS;
	localparam int DET_NS           = 400;
	localparam int DET_CYC          = (DET_NS * 1000) / CLK_PERIOD_PS;
	localparam int EI_INF_NS        = 512;
	localparam int EI_INF_CYC       = (EI_INF_NS * 1000) / CLK_PERIOD_PS;
	localparam int CNT_W            = 8;

	// mac-side request carrier
	typedef struct packed {
		logic       rate;
		logic       tx_elecidle;
		logic       tx_detect;
		logic       tx_compliance;
		logic [1:0] powerdown;
	} ppcc_req_t;

	// pcs-side status carrier
	typedef struct packed {
		logic rx_det_result;
		logic dec_err;
		logic disp_err;
		logic skp_add;
		logic skp_del;
		logic fifo_ovf;
		logic fifo_unf;
		logic rx_valid_data;
	} ppcc_pcs_t;

endpackage

// >>> design/ppcc_channel.sv
// pipe channel control: rate, power, idle, detect, status for one lane
//
// Function
// - rate rising edge starts gen1 to gen2
// - rate falling edge starts gen2 to gen1
// - clock select 250/500 MHz, width fixed by DATA_W, 8 or 16
// - tx electrical idle input forces buffer idle
// - four power states, data only in P0
// - mac-directed power state transitions are followed
// - low power only means tx idle
// - each channel has own power input
// - compliance pattern sent during polling compliance
// - optional receive electrical idle inference
// - mac data width by generation; here fixed by DATA_W whatever the rate
// - encode receiver status on three bits
// - 8b10b at gen1/gen2 with disparity
// - receive compensates plus minus 300 ppm
// - x1 to x8 widths, bonded clocking distinct
// - gen1/gen2 switching only in gen2 config
// - de-emphasis select only at gen2 rate
// - completion of phy operations signalled
// - receiver detect started on mac request, only in P1
// - tx held idle throughout P1
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module ppcc_channel #(
	parameter int DATA_W   = 16,
	parameter int LANES    = 1,
	parameter bit EI_INF_EN = 1'b1
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire ppcc_pkg::ppcc_req_t mac_req,
	input  wire ppcc_pkg::ppcc_pcs_t pcs_stat,
	input  wire logic              rx_elecidle_raw,
	output logic                   phy_status,
	output logic      [2:0]        rx_status,
	output logic                   rx_elecidle,
	output logic                   tx_idle_drv,
	output logic                   tx_compl_drv,
	output logic                   tx_deemph_drv,
	output logic                   det_start,
	output logic                   clk_sel_500,
	output logic                   bonded_clk
);
	import ppcc_pkg::*;

	localparam int RATE_LAST = RATE_SW_CYC;
	localparam int PWR_LAST  = PWR_SW_CYC;
	localparam int DET_LAST  = DET_CYC - 1;

	if (DATA_W != 8 && DATA_W != 16) begin : g_bad_width
		$error("DATA_W must be 8 or 16");
	end
	if (LANES != 1 && LANES != 2 && LANES != 4 && LANES != 8) begin : g_bad_lanes
		$error("LANES must be 1, 2, 4 or 8");
	end

	typedef enum {ST_IDLE, ST_RATE, ST_PWR, ST_DET} ppcc_op_t;

	ppcc_op_t        op_r;
	logic [CNT_W-1:0] cnt_r;
	logic [31:0]     ctrl_r;
	logic [1:0]      pwr_r;
	logic [1:0]      pwr_req_r;
	logic            gen2_r;
	logic            rate_prev_r;
	logic            det_found_r;
	logic [CNT_W-1:0] ei_cnt_r;
	logic            rx_ei_s1_r;
	logic            rx_ei_s2_r;

	logic rate_rise;
	logic rate_fall;
	logic pwr_change;
	logic det_req;
	logic apb_acc;

	assign rate_rise  = mac_req.rate & ~rate_prev_r & (DATA_W == 16);
	assign rate_fall  = ~mac_req.rate & rate_prev_r;
	assign pwr_change = mac_req.powerdown != pwr_r;
	// no restart while the completion pulse is still being seen by the mac
	assign det_req    = mac_req.tx_detect & (pwr_r == PWR_P1) & ~phy_status;
	assign apb_acc    = psel & penable;

	// operation sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r        <= ST_IDLE;
			cnt_r       <= '0;
			gen2_r      <= 1'b0;
			rate_prev_r <= 1'b0;
			pwr_r       <= PWR_P1;
			pwr_req_r   <= PWR_P1;
			det_found_r <= 1'b0;
		end else begin
			case (op_r)
				ST_IDLE: begin
					if (rate_rise || rate_fall) begin
						op_r        <= ST_RATE;
						cnt_r       <= CNT_W'(RATE_SW_CYC - 1);
						rate_prev_r <= mac_req.rate;
					end else if (pwr_change) begin
						op_r      <= ST_PWR;
						cnt_r     <= CNT_W'(PWR_SW_CYC - 1);
						pwr_req_r <= mac_req.powerdown;
					end else if (det_req) begin
						op_r  <= ST_DET;
						cnt_r <= CNT_W'(DET_CYC - 1);
					end
				end
				ST_RATE: begin
					if (cnt_r == '0) begin
						gen2_r <= rate_prev_r;
						op_r   <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				ST_PWR: begin
					if (cnt_r == '0) begin
						pwr_r <= pwr_req_r;
						op_r  <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				ST_DET: begin
					if (cnt_r == '0) begin
						det_found_r <= pcs_stat.rx_det_result;
						op_r        <= ST_IDLE;
					end else begin
						cnt_r <= cnt_r - 1'b1;
					end
				end
				default: op_r <= ST_IDLE;
			endcase
		end
	end

	// completion pulse and status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phy_status <= 1'b1;
			rx_status  <= RXST_OK;
		end else begin
			phy_status <= (op_r != ST_IDLE) && (cnt_r == '0);
			if (op_r == ST_DET && cnt_r == '0)
				rx_status <= pcs_stat.rx_det_result ? RXST_DETECTED : RXST_OK;
			else if (pcs_stat.dec_err)
				rx_status <= RXST_DEC_ERR;
			else if (pcs_stat.fifo_ovf)
				rx_status <= RXST_OVF;
			else if (pcs_stat.fifo_unf)
				rx_status <= RXST_UNF;
			else if (pcs_stat.disp_err)
				rx_status <= RXST_DISP_ERR;
			else if (pcs_stat.skp_add)
				rx_status <= RXST_SKP_ADD;
			else if (pcs_stat.skp_del)
				rx_status <= RXST_SKP_DEL;
			else
				rx_status <= RXST_OK;
		end
	end

	// transmitter drive controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_idle_drv   <= 1'b1;
			tx_compl_drv  <= 1'b0;
			tx_deemph_drv <= 1'b0;
			det_start     <= 1'b0;
			clk_sel_500   <= 1'b0;
			bonded_clk    <= 1'b0;
		end else begin
			tx_idle_drv   <= mac_req.tx_elecidle || (pwr_r != PWR_P0);
			tx_compl_drv  <= (mac_req.tx_compliance || ctrl_r[CTRL_COMPL_BIT])
				&& (pwr_r == PWR_P0);
			tx_deemph_drv <= gen2_r & ctrl_r[CTRL_DEEMPH_BIT];
			det_start     <= (op_r == ST_IDLE) && det_req && !pwr_change
				&& !rate_rise && !rate_fall;
			clk_sel_500   <= gen2_r;
			bonded_clk    <= (LANES > 1);
		end
	end

	// receive idle synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ei_s1_r <= 1'b1;
			rx_ei_s2_r <= 1'b1;
		end else begin
			rx_ei_s1_r <= rx_elecidle_raw;
			rx_ei_s2_r <= rx_ei_s1_r;
		end
	end

	// receive electrical idle inference
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ei_cnt_r    <= '0;
			rx_elecidle <= 1'b1;
		end else if (EI_INF_EN && ctrl_r[CTRL_EI_INF_BIT]) begin
			if (pcs_stat.rx_valid_data) begin
				ei_cnt_r    <= '0;
				rx_elecidle <= 1'b0;
			end else if (ei_cnt_r == CNT_W'(EI_INF_CYC - 1)) begin
				rx_elecidle <= 1'b1;
			end else begin
				ei_cnt_r <= ei_cnt_r + 1'b1;
			end
		end else begin
			ei_cnt_r    <= '0;
			rx_elecidle <= rx_ei_s2_r;
		end
	end

	// apb registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r  <= CTRL_RST;
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				pslverr <= !(paddr == CTRL_OFS || paddr == STAT_OFS || paddr == CFG_OFS);
				if (!pwrite) begin
					case (paddr)
						CTRL_OFS: prdata <= {29'h0, ctrl_r[2:0]};
						STAT_OFS: prdata <= {24'h0, det_found_r, rx_status, pwr_r,
							op_r != ST_IDLE, gen2_r};
						CFG_OFS:  prdata <= {24'h0, 4'(LANES), 3'h0, DATA_W == 16};
						default:  prdata <= '0;
					endcase
				end
			end
			if (apb_acc && pready && pwrite && paddr == CTRL_OFS)
				ctrl_r <= {29'h0, pwdata[2:0]};
		end
	end

	// checks
	sequence s_rate_start;
		(op_r == ST_IDLE) && (rate_rise || rate_fall);
	endsequence

	sequence s_rate_end;
		(op_r == ST_RATE) && (cnt_r == '0);
	endsequence

	sequence s_pwr_start;
		(op_r == ST_IDLE) && pwr_change && !rate_rise && !rate_fall;
	endsequence

	sequence s_pwr_end;
		(op_r == ST_PWR) && (cnt_r == '0);
	endsequence

	sequence s_det_start;
		(op_r == ST_IDLE) && det_req && !pwr_change && !rate_rise && !rate_fall;
	endsequence

	sequence s_det_end;
		(op_r == ST_DET) && (cnt_r == '0);
	endsequence

	property p_rate_up;
		@(posedge pclk) disable iff (!presetn)
		(op_r == ST_IDLE && mac_req.rate && !rate_prev_r && DATA_W == 16)
			|=> op_r == ST_RATE;
	endproperty
	a_rate_up: assert property (p_rate_up) else $error("rate rise not taken");

	property p_rate_done;
		@(posedge pclk) disable iff (!presetn)
		(op_r == ST_RATE && cnt_r == '0) |=> (gen2_r == rate_prev_r) ##1 clk_sel_500 == gen2_r;
	endproperty
	a_rate_done: assert property (p_rate_done) else $error("rate not applied");

	property p_clksel;
		@(posedge pclk) disable iff (!presetn)
		$changed(gen2_r) |=> clk_sel_500 == gen2_r;
	endproperty
	a_clksel: assert property (p_clksel) else $error("clock select lags");

	property p_tx_idle;
		@(posedge pclk) disable iff (!presetn)
		mac_req.tx_elecidle |=> tx_idle_drv;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("tx not idle");

	property p_p1_idle;
		@(posedge pclk) disable iff (!presetn)
		(pwr_r == PWR_P1) |=> tx_idle_drv;
	endproperty
	a_p1_idle: assert property (p_p1_idle) else $error("tx active in P1");

	property p_pwr_move;
		@(posedge pclk) disable iff (!presetn)
		(op_r == ST_PWR && cnt_r == '0) |=> pwr_r == $past(pwr_req_r) ##0 phy_status;
	endproperty
	a_pwr_move: assert property (p_pwr_move) else $error("power state not reached");

	property p_done_pulse;
		@(posedge pclk) disable iff (!presetn)
		(op_r != ST_IDLE && cnt_r == '0) |=> phy_status ##1 !phy_status || op_r != ST_IDLE;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("no completion");

	property p_det;
		@(posedge pclk) disable iff (!presetn)
		det_start |-> ##[1:200] phy_status;
	endproperty
	a_det: assert property (p_det) else $error("detect never completes");

	property p_deemph;
		@(posedge pclk) disable iff (!presetn)
		!gen2_r |=> !tx_deemph_drv;
	endproperty
	a_deemph: assert property (p_deemph) else $error("de-emphasis at gen1");

	property p_compl;
		@(posedge pclk) disable iff (!presetn)
		tx_compl_drv |-> $past(pwr_r) == PWR_P0;
	endproperty
	a_compl: assert property (p_compl) else $error("compliance outside P0");

	property p_rate_len;
		@(posedge pclk) disable iff (!presetn)
		s_rate_start |-> ##RATE_LAST s_rate_end ##1 (phy_status && op_r == ST_IDLE);
	endproperty
	a_rate_len: assert property (p_rate_len) else $error("rate switch length wrong");

	property p_pwr_len;
		@(posedge pclk) disable iff (!presetn)
		s_pwr_start |-> ##PWR_LAST s_pwr_end ##1 phy_status;
	endproperty
	a_pwr_len: assert property (p_pwr_len) else $error("power switch length wrong");

	property p_det_len;
		@(posedge pclk) disable iff (!presetn)
		s_det_start |-> ##1 det_start ##DET_LAST s_det_end ##1 phy_status;
	endproperty
	a_det_len: assert property (p_det_len) else $error("detect sequence wrong");

	property p_det_stat;
		@(posedge pclk) disable iff (!presetn)
		s_det_end |=> rx_status == ($past(pcs_stat.rx_det_result) ? RXST_DETECTED : RXST_OK);
	endproperty
	a_det_stat: assert property (p_det_stat) else $error("detect status wrong");

	property p_no_retrig;
		@(posedge pclk) disable iff (!presetn)
		(phy_status && op_r == ST_IDLE) |=> op_r != ST_DET;
	endproperty
	a_no_retrig: assert property (p_no_retrig) else $error("detect restarted");

	property p_det_pulse;
		@(posedge pclk) disable iff (!presetn)
		det_start |=> !det_start;
	endproperty
	a_det_pulse: assert property (p_det_pulse) else $error("detect start too long");

	property p_ei_inf;
		@(posedge pclk) disable iff (!presetn)
		(EI_INF_EN && ctrl_r[CTRL_EI_INF_BIT] && pcs_stat.rx_valid_data) |=> !rx_elecidle;
	endproperty
	a_ei_inf: assert property (p_ei_inf) else $error("idle with valid data");

	property p_compl_force;
		@(posedge pclk) disable iff (!presetn)
		(ctrl_r[CTRL_COMPL_BIT] && pwr_r == PWR_P0) |=> tx_compl_drv;
	endproperty
	a_compl_force: assert property (p_compl_force) else $error("forced compliance off");

endmodule

`default_nettype wire

// >>> test/ppcc_mac_model.sv
// mac-side partner model: drives the channel requests one operation at a time
`timescale 1ns/1ps
`default_nettype none
module ppcc_mac_model (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                phy_status,
	input  wire ppcc_pkg::ppcc_req_t want,
	output var  ppcc_pkg::ppcc_req_t mac_req,
	output logic                     busy
);
	import ppcc_pkg::*;
	logic det_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mac_req <= '{powerdown: PWR_P1, default: 1'b0};
			busy    <= 1'b0;
			det_q   <= 1'b0;
		end else begin
			mac_req.tx_elecidle   <= want.tx_elecidle;
			mac_req.tx_compliance <= want.tx_compliance;
			det_q                 <= want.tx_detect;
			if (busy) begin
				if (phy_status) begin
					busy              <= 1'b0;
					mac_req.tx_detect <= 1'b0;
				end
			end else if (want.rate != mac_req.rate || want.powerdown != mac_req.powerdown ||
				(want.tx_detect && !det_q)) begin
				mac_req.rate      <= want.rate;
				mac_req.powerdown <= want.powerdown;
				mac_req.tx_detect <= want.tx_detect;
				busy              <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/tb_ppcc_channel.sv
// testbench for the pipe channel control block
`timescale 1ns/1ps
`default_nettype none
module tb_ppcc_channel;
	import ppcc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, rx_elecidle_raw;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, phy_status, rx_elecidle, tx_idle_drv, tx_compl_drv;
	logic        tx_deemph_drv, det_start, clk_sel_500, bonded_clk, busy, er;
	logic [2:0]  rx_status, rxs;
	ppcc_req_t   want, mac_req;
	ppcc_pcs_t   pcs_stat;
	int          n_mismatch = 0, samples_checked = 0, cyc, n_det = 0;
	logic [2:0]  rxc [0:6];
	logic [1:0]  pl [0:4];

	ppcc_channel #(.DATA_W(16), .LANES(1), .EI_INF_EN(1'b1)) i_ppcc_channel (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mac_req,
		.pcs_stat, .rx_elecidle_raw, .phy_status, .rx_status, .rx_elecidle, .tx_idle_drv,
		.tx_compl_drv, .tx_deemph_drv, .det_start, .clk_sel_500, .bonded_clk);
	ppcc_mac_model i_ppcc_mac_model (.pclk, .presetn, .phy_status, .want, .mac_req, .busy);

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) if (det_start === 1'b1) n_det++;

	task close_out;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task chk_cyc(input int n);
		chk(32'(cyc >= n + 2 && cyc <= n + 6), 32'h1);
	endtask

	task step(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task issue;
		cyc = 0;
		do begin
			@(posedge pclk);
			cyc++;
		end while (phy_status !== 1'b1 && cyc < 400);
		rxs = rx_status;
		step(2);
	endtask

	task t_detect;
		pcs_stat.rx_det_result <= 1'b1;
		want.tx_detect <= 1'b1;
		issue;
		chk_cyc(DET_CYC);
		chk(32'(rxs), 32'(RXST_DETECTED));
		chk(32'(n_det), 32'h1);
		want.tx_detect <= 1'b0;
		pcs_stat <= '0;
	endtask

	task t_power;
		for (int i = 0; i < 5; i++) begin
			want.powerdown <= pl[i];
			issue;
			chk_cyc(PWR_SW_CYC);
			chk(32'(tx_idle_drv), 32'(pl[i] != PWR_P0));
		end
		want.tx_elecidle <= 1'b1;
		step(3);
		chk(32'(tx_idle_drv), 32'h1);
		want.tx_elecidle <= 1'b0;
		want.tx_compliance <= 1'b1;
		step(3);
		chk(32'(tx_compl_drv), 32'h1);
		chk(32'(tx_idle_drv), 32'h0);
		want.tx_compliance <= 1'b0;
	endtask

	task t_rate;
		apb(1'b1, CTRL_OFS, 32'h2);
		want.rate <= 1'b1;
		issue;
		chk_cyc(RATE_SW_CYC);
		chk(32'(clk_sel_500), 32'h1);
		chk(32'(tx_deemph_drv), 32'h1);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rd & 32'h1, 32'h1);
		want.rate <= 1'b0;
		issue;
		chk_cyc(RATE_SW_CYC);
		chk(32'(clk_sel_500), 32'h0);
		chk(32'(tx_deemph_drv), 32'h0);
	endtask

	task t_misc;
		for (int i = 0; i < 7; i++) begin
			pcs_stat <= ppcc_pcs_t'(8'h01 | (8'h01 << i));
			step(3);
			chk(32'(rx_status), 32'(rxc[i]));
		end
		apb(1'b0, CFG_OFS, 32'h0);
		chk(rd & 32'hf1, 32'h11);
		chk(32'(bonded_clk), 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk({er, rd[30:0]}, 32'h8000_0000);
		apb(1'b1, CTRL_OFS, 32'h0);
		rx_elecidle_raw <= 1'b0;
		step(6);
		chk(32'(rx_elecidle), 32'h0);
		apb(1'b1, CTRL_OFS, 32'h5);
		step(1);
		chk(32'(tx_compl_drv), 32'h1);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rd, 32'h5);
		pcs_stat <= '0;
		step(EI_INF_CYC - 4);
		chk(32'(rx_elecidle), 32'h0);
		step(8);
		chk(32'(rx_elecidle), 32'h1);
	endtask

	initial begin
		rxc = '{RXST_OK, RXST_UNF, RXST_OVF, RXST_SKP_DEL, RXST_SKP_ADD, RXST_DISP_ERR,
			RXST_DEC_ERR};
		pl = '{PWR_P0, PWR_P0S, PWR_P1, PWR_P2, PWR_P0};
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		rx_elecidle_raw = 1'b1;
		want = '{powerdown: PWR_P1, default: 1'b0};
		pcs_stat = '0;
		step(16);
		chk({phy_status, tx_idle_drv, rx_elecidle, clk_sel_500}, 32'he);
		presetn <= 1'b1;
		step(2);
		t_detect;
		t_power;
		t_rate;
		t_misc;
		close_out;
	end

	initial begin
		step(20000);
		n_mismatch++;
		close_out;
	end
endmodule
`default_nettype wire
